// File: hw/system_watchdog_timer.sv
// Purpose: fail-safe watchdog with prescaled slow tick and two actions
// Assumes: slow_clk_32k is a free level input much slower than sys_clk
// Notes: registers reached over classic Wishbone, zero wait state + 1
//
// Behaviour
// - non-zero timeout write enables, loads counter, restarts countdown
// - expiry with overflow clear reloads timeout and keeps counting
// - disabled by system reset, zero timeout write, or repeat expiry
// - 16-bit down counter stepped by prescaled slow-clock tick
// - prescale code divides slow clock by two to the code power, codes above 13 by 8192
// - slow clock gated only while suspend low and power-down set
// - power-down bit cleared at power-on and suspend rising edge
// - first expiry produces the first expiry action
// - repeat expiry produces repeat action then stops the timer
// - action codes: none, interrupt, SMI, system reset
// - interrupt and SMI held until overflow flag is cleared
// - overflow and action fields cleared by power-on reset only
// - overflow set on expiry, cleared by power-on or writing one
// - asserted flags set at expiry for the chosen action, even with route zero, cleared with overflow flag
// - interrupt is active-low level request routed by route field
// - SMI output drives core logic SMI input zero
// - reset action requests full system reset from core logic
// - route code zero disables, others select an IRQ line

`timescale 1ns/1ps
`default_nettype none

module system_watchdog_timer
  import watchdog_pkg::*;
(
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // other system reset sources, level, synchronous
  input wire logic sys_reset_b,
  // slow clock and cpu suspend indication
  input wire logic slow_clk_32k,
  input wire logic cpu_suspend_ack_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event outputs
  output logic irq_req_n,
  output logic [3:0] irq_route_field,
  output logic core_smi_input_zero_n,
  output logic sys_reset_req
);

  // ==========================================================
  // reset release
  logic por_meta_b;
  logic por_b;

  // assert at once, release through two flops to avoid recovery races
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      por_meta_b <= 1'b0;
      por_b <= 1'b0;
    end else begin
      por_meta_b <= 1'b1;
      por_b <= por_meta_b;
    end
  end

  // ==========================================================
  // register bus decode
  logic ack_q;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic hit_to;
  logic hit_cfg;
  logic hit_sts;
  logic hit_cnt;
  logic hit_route;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign idx = wb_adr_i[ADDR_W-1:2];
  assign wb_ack_o = ack_q;

  // address decode; unmapped words still ack, read zero, ignore writes
  always_comb begin
    hit_to = 1'b0;
    hit_cfg = 1'b0;
    hit_sts = 1'b0;
    hit_cnt = 1'b0;
    hit_route = 1'b0;
    if (idx == IDX_TIMEOUT_PERIOD) begin
      hit_to = 1'b1;
    end else if (idx == IDX_WATCHDOG_CONFIG) begin
      hit_cfg = 1'b1;
    end else if (idx == IDX_WATCHDOG_STATUS) begin
      hit_sts = 1'b1;
    end else if (idx == IDX_COUNT_VALUE) begin
      hit_cnt = 1'b1;
    end else if (idx == IDX_IRQ_ROUTE_SELECT) begin
      hit_route = 1'b1;
    end
  end

  // one ack per request, dropped the cycle after
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // ==========================================================
  // software registers
  logic [15:0] timeout_q;
  logic [3:0] prescale_q;
  action_t first_act_q;
  action_t repeat_act_q;
  logic pd_q;
  logic [3:0] route_q;
  logic [15:0] wdata16;
  logic [15:0] to_merged;
  logic to_wr;
  logic susp_q;

  // byte-lane merge of a 16-bit register write
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      res[15:8] = nw[15:8];
    end
    return res;
  endfunction

  assign wdata16 = wb_dat_i[15:0];
  assign to_merged = merge16(timeout_q, wdata16, wb_sel_i[1:0]);
  assign to_wr = wr & hit_to & (|wb_sel_i[1:0]);

  // timeout period; other system resets clear it too
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      timeout_q <= TIMEOUT_RESET;
    end else if (!sys_reset_b) begin
      timeout_q <= TIMEOUT_RESET;
    end else if (to_wr) begin
      timeout_q <= to_merged;
    end
  end

  // prescale follows any system reset
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      prescale_q <= CONFIG_RESET[CFG_PRESCALE_LSB +: 4];
    end else if (!sys_reset_b) begin
      prescale_q <= CONFIG_RESET[CFG_PRESCALE_LSB +: 4];
    end else if (wr & hit_cfg & wb_sel_i[0]) begin
      prescale_q <= wb_dat_i[CFG_PRESCALE_LSB +: 4];
    end
  end

  // action fields survive every reset but power-on
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      first_act_q <= ACT_NONE;
      repeat_act_q <= ACT_NONE;
    end else if (wr & hit_cfg & wb_sel_i[0]) begin
      first_act_q <= action_t'(wb_dat_i[CFG_FIRST_LSB +: 2]);
      repeat_act_q <= action_t'(wb_dat_i[CFG_REPEAT_LSB +: 2]);
    end
  end

  // power-down bit; suspend release beats a same-cycle software set
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      susp_q <= 1'b1;
      pd_q <= CONFIG_RESET[CFG_PD_BIT];
    end else begin
      susp_q <= cpu_suspend_ack_n;
      if (cpu_suspend_ack_n & ~susp_q) begin
        pd_q <= 1'b0;
      end else if (wr & hit_cfg & wb_sel_i[1]) begin
        pd_q <= wb_dat_i[CFG_PD_BIT];
      end
    end
  end

  // interrupt routing, shared with other timer interrupts
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      route_q <= ROUTE_RESET;
    end else if (wr & hit_route & wb_sel_i[0]) begin
      route_q <= wb_dat_i[3:0];
    end
  end

  // ==========================================================
  // slow clock tick
  logic slow_meta;
  logic slow_sync;
  logic slow_prev;
  logic slow_edge;
  logic slow_run;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_top;
  logic tick;

  // two-flop sync, edge taken from the second stage only
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      slow_meta <= slow_clk_32k;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
    end
  end

  assign slow_run = cpu_suspend_ack_n | ~pd_q;
  assign slow_edge = slow_sync & ~slow_prev & slow_run;

  // reserved codes divide by the largest ratio
  always_comb begin
    if (prescale_q > PRESCALE_MAX_CODE) begin
      div_top = DIV_W'((1 << PRESCALE_MAX_CODE) - 1);
    end else begin
      div_top = DIV_W'((1 << prescale_q) - 1);
    end
  end

  assign tick = slow_edge & (div_q >= div_top);

  // power-of-two divider of gated slow edges
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      div_q <= '0;
    end else if (!sys_reset_b || to_wr) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else if (slow_edge) begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // ==========================================================
  // countdown
  wd_state_t state_q;
  logic [15:0] count_q;
  logic expire;
  logic expire_first;
  logic expire_repeat;
  logic ovf_q;
  action_t act;

  assign expire = (state_q == WD_RUN) & tick & (count_q == 16'h0001);
  assign expire_first = expire & ~ovf_q;
  assign expire_repeat = expire & ovf_q;
  assign act = ovf_q ? repeat_act_q : first_act_q;

  // state and counter; a bus write outranks a tick in the same cycle
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      state_q <= WD_IDLE;
      count_q <= 16'h0000;
    end else if (!sys_reset_b) begin
      state_q <= WD_IDLE;
      count_q <= 16'h0000;
    end else if (to_wr) begin
      if (to_merged != 16'h0000) begin
        state_q <= WD_RUN;
        count_q <= to_merged;
      end else begin
        state_q <= WD_IDLE;
        count_q <= 16'h0000;
      end
    end else begin
      case (state_q)
        WD_IDLE: begin
          count_q <= count_q;
        end
        WD_RUN: begin
          if (expire_first) begin
            count_q <= timeout_q;
          end else if (expire_repeat) begin
            state_q <= WD_IDLE;
            count_q <= 16'h0000;
          end else if (tick) begin
            count_q <= count_q - 16'h0001;
          end
        end
        default: begin
          state_q <= WD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // overflow and asserted flags
  logic ovf_clr;
  logic irq_flag_q;
  logic smi_flag_q;
  logic rst_flag_q;
  logic [7:0] rst_cnt_q;

  // a same-cycle expiry wins over the software clear
  assign ovf_clr = wr & hit_sts & wb_sel_i[0] & wb_dat_i[STS_OVF_BIT]
                   & ~expire;

  // overflow: power-on reset only, write one to clear
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      ovf_q <= 1'b0;
    end else if (expire) begin
      ovf_q <= 1'b1;
    end else if (ovf_clr) begin
      ovf_q <= 1'b0;
    end
  end

  // irq and smi stay up until overflow is cleared
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      irq_flag_q <= 1'b0;
      smi_flag_q <= 1'b0;
      rst_flag_q <= 1'b0;
    end else if (expire) begin
      if (act == ACT_IRQ) begin
        irq_flag_q <= 1'b1;
      end
      if (act == ACT_SMI) begin
        smi_flag_q <= 1'b1;
      end
      if (act == ACT_RESET) begin
        rst_flag_q <= 1'b1;
      end
    end else if (ovf_clr) begin
      irq_flag_q <= 1'b0;
      smi_flag_q <= 1'b0;
      rst_flag_q <= 1'b0;
    end
  end

  // reset request is a fixed pulse, so it cannot lock the system in reset
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      rst_cnt_q <= 8'h00;
    end else if (expire && act == ACT_RESET) begin
      rst_cnt_q <= 8'(RESET_PULSE_CYC);
    end else if (rst_cnt_q != 8'h00) begin
      rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      irq_req_n <= 1'b1;
      irq_route_field <= ROUTE_RESET;
      core_smi_input_zero_n <= 1'b1;
      sys_reset_req <= 1'b0;
    end else begin
      irq_req_n <= ~(irq_flag_q & (route_q != 4'h0));
      irq_route_field <= route_q;
      core_smi_input_zero_n <= ~smi_flag_q;
      sys_reset_req <= (rst_cnt_q != 8'h00);
    end
  end

  // read data, registered with the ack
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_to) begin
      rdata[15:0] = timeout_q;
    end else if (hit_cfg) begin
      rdata[CFG_PRESCALE_LSB +: 4] = prescale_q;
      rdata[CFG_FIRST_LSB +: 2] = first_act_q;
      rdata[CFG_REPEAT_LSB +: 2] = repeat_act_q;
      rdata[CFG_PD_BIT] = pd_q;
    end else if (hit_sts) begin
      rdata[STS_OVF_BIT] = ovf_q;
      rdata[STS_IRQ_BIT] = irq_flag_q;
      rdata[STS_SMI_BIT] = smi_flag_q;
      rdata[STS_RST_BIT] = rst_flag_q;
    end else if (hit_cnt) begin
      rdata[15:0] = count_q;
    end else if (hit_route) begin
      rdata[3:0] = route_q;
    end
  end

  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_we_i) begin
      wb_dat_o <= rdata;
    end
  end

endmodule

`default_nettype wire

// File: hw/watchdog_pkg.sv
// Purpose: shared constants and types for the system watchdog timer
// Assumes: 32-bit classic Wishbone slave, one aligned word per register
// Notes: register index times four gives the byte address

package watchdog_pkg;

  // ==========================================================
  // register map (index = printed offset, byte address = 4x)
  localparam logic [7:0] IDX_TIMEOUT_PERIOD = 8'h00;
  localparam logic [7:0] IDX_WATCHDOG_CONFIG = 8'h02;
  localparam logic [7:0] IDX_WATCHDOG_STATUS = 8'h04;
  localparam logic [7:0] IDX_COUNT_VALUE = 8'h06;
  localparam logic [7:0] IDX_IRQ_ROUTE_SELECT = 8'h38;
  localparam int ADDR_W = 10;

  // ==========================================================
  // reset values
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [3:0] ROUTE_RESET = 4'h0;

  // ==========================================================
  // watchdog_config field positions
  localparam int CFG_PRESCALE_LSB = 0;
  localparam int CFG_FIRST_LSB = 4;
  localparam int CFG_REPEAT_LSB = 6;
  localparam int CFG_PD_BIT = 8;

  // watchdog_status bit positions
  localparam int STS_OVF_BIT = 0;
  localparam int STS_IRQ_BIT = 1;
  localparam int STS_SMI_BIT = 2;
  localparam int STS_RST_BIT = 3;

  // prescale codes: 0000 divides by 1 up to 1101 by 8192
  localparam logic [3:0] PRESCALE_MAX_CODE = 4'hD;
  localparam int DIV_W = 13;

  // ==========================================================
  // timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * SYS_CLK_MHZ) / 1000;

  // expiry action encoding
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_IRQ = 2'b01,
    ACT_SMI = 2'b10,
    ACT_RESET = 2'b11
  } action_t;

  // countdown state
  typedef enum logic {
    WD_IDLE = 1'b0,
    WD_RUN = 1'b1
  } wd_state_t;

endpackage

// File: verification/slow_clock_src.sv
// Purpose: free-running slow clock source facing the watchdog
// Assumes: sys_clk runs; HALF sys_clk cycles per half period
// Notes: sped up so that many expiries fit in a short run
`timescale 1ns/1ps
`default_nettype none
module slow_clock_src #(
  parameter int HALF = 20
) (
  // timing reference
  input wire logic sys_clk,
  // slow clock level
  output var logic slow_clk_32k
);
  // ==========================================================
  // divider
  int cnt_q = 0;
  logic slow_q = 1'b0;
  // runs free, so only the power-down gate may stop the watchdog tick
  always @(posedge sys_clk) begin
    cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
    if (cnt_q == HALF - 1) slow_q <= ~slow_q;
  end
  assign slow_clk_32k = slow_q;
endmodule
`default_nettype wire

// File: verification/watchdog_assertions.sv
// Purpose: port-level checker for the system watchdog timer
// Assumes: classic Wishbone, registered outputs
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module watchdog_checker
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sys_reset_b,
  input wire logic slow_clk_32k,
  input wire logic cpu_suspend_ack_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // events
  input wire logic irq_req_n,
  input wire logic [3:0] irq_route_field,
  input wire logic core_smi_input_zero_n,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // helpers
  logic w;
  logic [7:0] pulse_q;
  assign w = wb_cyc_i && wb_stb_i && wb_we_i;
  // length of the reset request seen so far
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) pulse_q <= 8'h00;
    else pulse_q <= sys_reset_req ? pulse_q + 8'h01 : 8'h00;
  end
  // ==========================================================
  // properties
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_spurious_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  irq_route_a: assert property (!irq_req_n |-> irq_route_field != 4'h0)
    else $error("interrupt with route disabled");
  irq_hold_a: assert property (!irq_req_n && !w |=> !irq_req_n)
    else $error("interrupt dropped without write");
  smi_hold_a: assert property (!core_smi_input_zero_n && !w
    |=> !core_smi_input_zero_n)
    else $error("smi dropped without write");
  route_copy_a: assert property (!w && !$past(w)
    |=> $stable(irq_route_field)) else $error("route moved");
  reset_width_a: assert property ($fell(sys_reset_req)
    |-> pulse_q == RESET_PULSE_CYC)
    else $error("reset request width wrong");
endmodule
bind system_watchdog_timer watchdog_checker chk (.sys_clk(sys_clk),
  .rst_b(rst_b), .sys_reset_b(sys_reset_b), .slow_clk_32k(slow_clk_32k),
  .cpu_suspend_ack_n(cpu_suspend_ack_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_req_n(irq_req_n),
  .irq_route_field(irq_route_field),
  .core_smi_input_zero_n(core_smi_input_zero_n),
  .sys_reset_req(sys_reset_req));
`default_nettype wire

// File: verification/system_watchdog_timer_tb_top.sv
// Purpose: self-checking bench for the system watchdog timer
// Assumes: slow clock period of 40 sys_clk cycles
// Notes: expiry is seen by polling status over the bus, or on the reset request output in the reset-action test
`timescale 1ns/1ps
`default_nettype none
module system_watchdog_timer_tb_top;
  import watchdog_pkg::*;
  // ==========================================================
  // stimulus and wiring
  localparam logic [9:0] A_TO = {IDX_TIMEOUT_PERIOD, 2'b00};
  localparam logic [9:0] A_CF = {IDX_WATCHDOG_CONFIG, 2'b00};
  localparam logic [9:0] A_ST = {IDX_WATCHDOG_STATUS, 2'b00};
  localparam logic [9:0] A_CV = {IDX_COUNT_VALUE, 2'b00};
  localparam logic [9:0] A_RT = {IDX_IRQ_ROUTE_SELECT, 2'b00};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sys_reset_b = 1'b1;
  logic susp_n = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack, irq_n, smi_n, rst_req, slow;
  logic [3:0] route;
  int failures = 0;
  int n_checks = 0;
  int slow_n = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge slow) slow_n++;
  system_watchdog_timer dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .sys_reset_b(sys_reset_b), .slow_clk_32k(slow),
    .cpu_suspend_ack_n(susp_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_req_n(irq_n),
    .irq_route_field(route), .core_smi_input_zero_n(smi_n),
    .sys_reset_req(rst_req));
  slow_clock_src #(.HALF(20)) src (.sys_clk(sys_clk), .slow_clk_32k(slow));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held until ack is sampled; read data taken at that edge
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (k >= 40) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [9:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // bounded poll until all bits of m are set in status
  task automatic wait_sts(input logic [31:0] m);
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      xfer(1'b0, A_ST, 32'h0, q);
      k++;
    end while ((q & m) !== m && k < 300);
    if (k >= 300) failures++;
  endtask
  task automatic slow_wait(input int n);
    repeat (n) @(posedge slow);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_reset();
    rd("timeout", A_TO, 32'h0);
    rd("config", A_CF, 32'h0);
    rd("route", A_RT, 32'h0);
    wr(A_ST, 32'h0000_000E);
    rd("status ro", A_ST, 32'h0);
    rd("unmapped", 10'h3FC, 32'h0);
    chk("irq idle", 1'b1, irq_n);
  endtask
  task automatic s_two_expiry();
    wr(A_RT, 32'h3);
    wr(A_CF, 32'h90);
    slow_wait(1);
    repeat (5) @(posedge sys_clk);
    wr(A_TO, 32'h3);
    rd("loaded", A_CV, 32'h3);
    wait_sts(32'h1);
    rd("first", A_ST, 32'h3);
    chk("irq on", 1'b0, irq_n);
    chk("route out", 4'h3, route);
    chk("smi off", 1'b1, smi_n);
    wait_sts(32'h4);
    rd("second", A_ST, 32'h7);
    chk("smi on", 1'b0, smi_n);
    slow_wait(8);
    rd("stopped", A_CV, 32'h0);
    chk("irq held", 1'b0, irq_n);
    wr(A_ST, 32'h1);
    rd("cleared", A_ST, 32'h0);
    chk("irq off", 1'b1, irq_n);
    chk("smi off", 1'b1, smi_n);
  endtask
  task automatic s_reset_action();
    int n;
    n = 0;
    wr(A_CF, 32'h30);
    wr(A_TO, 32'h1);
    while (rst_req !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (rst_req === 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("pulse", RESET_PULSE_CYC, n);
    @(posedge sys_clk);
    sys_reset_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sys_reset_b <= 1'b1;
    rd("to sysrst", A_TO, 32'h0);
    rd("cf sysrst", A_CF, 32'h30);
    rd("st sysrst", A_ST, 32'h9);
    wr(A_ST, 32'h1);
  endtask
  task automatic s_zero_and_prescale();
    wr(A_CF, 32'h0);
    wr(A_TO, 32'h4);
    wr(A_TO, 32'h0);
    slow_wait(12);
    rd("no expiry", A_ST, 32'h0);
    wr(A_RT, 32'h0);
    wr(A_CF, 32'h12);
    wr(A_TO, 32'h1);
    slow_n = 0;
    wait_sts(32'h1);
    chk("div4", 1'b1, slow_n >= 3 && slow_n <= 5);
    rd("route off", A_ST, 32'h3);
    chk("irq gated", 1'b1, irq_n);
    wr(A_ST, 32'h1);
  endtask
  task automatic s_power_down();
    @(posedge sys_clk);
    susp_n <= 1'b0;
    wr(A_CF, 32'h100);
    rd("pd set", A_CF, 32'h100);
    wr(A_TO, 32'h1);
    slow_wait(6);
    rd("frozen", A_ST, 32'h0);
    @(posedge sys_clk);
    susp_n <= 1'b1;
    slow_wait(4);
    rd("pd clear", A_CF, 32'h0);
    rd("resumed", A_ST, 32'h1);
    chk("no smi", 1'b1, smi_n);
  endtask
  // ==========================================================
  // run control
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // run needs about two thousand cycles; limit is nearly twenty times that
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    s_reset();
    s_two_expiry();
    s_reset_action();
    s_zero_and_prescale();
    s_power_down();
    give_verdict();
  end
endmodule
`default_nettype wire
